// >>> design/tmh_params.svh
`ifndef TMH_PARAMS_SVH
`define TMH_PARAMS_SVH
`define TMH_OFF_PERIOD 8'h00
`define TMH_OFF_COUNT 8'h04
`define TMH_OFF_CONTROL 8'h08
`define TMH_OFF_CLKSEL 8'h0C
`define TMH_OFF_RSTSEL 8'h10
`define TMH_OFF_LIMIT 8'h14
`define TMH_RST_BYTE 8'h00
`define TMH_RST_WORD 32'h0000_0000
`define TMH_ON_BIT 7
`define TMH_PRESCALER_SYNC_ENABLE_BIT 7
`define TMH_CLOCK_EDGE_SELECT_BIT 6
`define TMH_ON_BIT_SYNC_ENABLE_BIT 5
`define TMH_SRC_PIN 5'h00
`define TMH_SRC_SIB_HI 5'h03
`define TMH_SRC_CCP_LO 5'h04
`define TMH_SRC_CCP_HI 5'h05
`define TMH_SRC_PWM_LO 5'h06
`define TMH_SRC_PWM_HI 5'h09
`define TMH_SRC_CMP_LO 5'h0A
`define TMH_SRC_CMP_HI 5'h0D
`define TMH_SRC_ZCD 5'h0E
`define TMH_SRC_LC_LO 5'h0F
`define TMH_SRC_LC_HI 5'h11
`define TMH_MODE_MONO_RISE 5'h11
`define TMH_MODE_MONO_FALL 5'h12
`define TMH_MODE_MONO_BOTH 5'h13
`define TMH_MODE_LVL_LOW 5'h16
`define TMH_MODE_LVL_HIGH 5'h17
`endif

// >>> design/tmh_pkg.sv
package tmh_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tmh_apb_req_s;
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } tmh_apb_rsp_s;
    typedef struct packed {
        logic       inputPin;
        logic [2:0] sibling;
        logic [1:0] ccp;
        logic [3:0] pwm;
        logic [3:0] cmp;
        logic       zcd;
        logic [2:0] lc;
    } tmh_src_s;
    typedef struct packed {
        tmh_apb_rsp_s rsp;
        logic [7:0]   period;
        logic [7:0]   count;
        logic [7:0]   control;
        logic [3:0]   clkSel;
        logic [4:0]   rstSel;
        logic [7:0]   limit;
        logic [7:0]   periodBuf;
        logic [2:0]   clkSync;
        logic         clkLvl;
        logic         tickHold;
        logic [2:0]   extSync;
        logic         extLvl;
        logic         extCur;
        logic [1:0]   onSync;
        logic         started;
        logic         running;
        logic         extOut;
    } tmh_state_s;
endpackage

// >>> design/tmh_timer.sv
`timescale 1ns/1ps
`include "tmh_params.svh"
module tmh_timer
    import tmh_pkg::*;
#(
    parameter logic [4:0] SELF_SRC = 5'h01
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire tmh_apb_req_s apbReq,
    output tmh_apb_rsp_s      apbRsp,
    input  wire logic         timerClkIn,
    input  wire logic         sleepMode,
    input  wire tmh_src_s     srcIn,
    output logic [7:0]        timerCount,
    output logic [7:0]        periodBufOut,
    output logic              timerRunning,
    output logic [4:0]        modeCode,
    output logic              extResetLevel
);
    tmh_state_s st;
    tmh_state_s next_st;

    // Level filter: accept the change once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    logic       acc;
    logic       wrEn;
    logic       clkNew;
    logic       rawTick;
    logic       tick;
    logic       onBit;
    logic       effOn;
    logic       extSel;
    logic       extValid;
    logic       extNew;
    logic       extRise;
    logic       extFall;
    logic       match;
    logic [4:0] mode;
    logic [4:0] src;
    logic [31:0] rdData;
    logic        unmapped;

    // External reset source select
    always_comb begin
        src = st.rstSel;
        extSel = 1'b0;
        extValid = 1'b1;
        if (src == `TMH_SRC_PIN) begin
            extSel = srcIn.inputPin;
        end else if (src <= `TMH_SRC_SIB_HI) begin
            extSel = srcIn.sibling[src[1:0] - 2'd1];
            extValid = (src != SELF_SRC);
        end else if (src <= `TMH_SRC_CCP_HI) begin
            extSel = srcIn.ccp[src[0]];
        end else if (src <= `TMH_SRC_PWM_HI) begin
            extSel = srcIn.pwm[2'(src - `TMH_SRC_PWM_LO)];
        end else if (src <= `TMH_SRC_CMP_HI) begin
            extSel = srcIn.cmp[2'(src - `TMH_SRC_CMP_LO)];
        end else if (src == `TMH_SRC_ZCD) begin
            extSel = srcIn.zcd;
        end else if (src <= `TMH_SRC_LC_HI) begin
            extSel = srcIn.lc[2'(src - `TMH_SRC_LC_LO)];
        end else begin
            extValid = 1'b0;
        end
        if (!extValid) begin
            extSel = 1'b0;
        end
    end

    // Register read mux
    always_comb begin
        rdData = `TMH_RST_WORD;
        unmapped = 1'b0;
        case (apbReq.paddr)
            `TMH_OFF_PERIOD: begin
                rdData[7:0] = st.period;
            end
            `TMH_OFF_COUNT: begin
                rdData[7:0] = st.count;
            end
            `TMH_OFF_CONTROL: begin
                rdData[7:0] = st.control;
            end
            `TMH_OFF_CLKSEL: begin
                rdData[3:0] = st.clkSel;
            end
            `TMH_OFF_RSTSEL: begin
                rdData[4:0] = st.rstSel;
            end
            `TMH_OFF_LIMIT: begin
                rdData[7:0] = st.limit;
            end
            default: begin
                unmapped = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        acc = apbReq.psel & apbReq.penable;
        wrEn = acc & st.rsp.pready & apbReq.pwrite;
        mode = st.limit[4:0];
        onBit = st.control[`TMH_ON_BIT];

        // Timer input clock: three stages then filter
        next_st.clkSync = {st.clkSync[1:0], timerClkIn};
        clkNew = filt(st.clkSync, st.clkLvl);
        next_st.clkLvl = clkNew;
        if (st.limit[`TMH_CLOCK_EDGE_SELECT_BIT]) begin
            rawTick = st.clkLvl & ~clkNew;
        end else begin
            rawTick = ~st.clkLvl & clkNew;
        end
        next_st.tickHold = rawTick;
        if (st.limit[`TMH_PRESCALER_SYNC_ENABLE_BIT]) begin
            tick = st.tickHold & ~sleepMode;
        end else begin
            tick = rawTick;
        end

        // On bit, optionally synchronised to timer clock ticks
        if (tick) begin
            next_st.onSync = {st.onSync[0], onBit};
        end
        if (st.limit[`TMH_ON_BIT_SYNC_ENABLE_BIT]) begin
            effOn = st.onSync[1];
        end else begin
            effOn = onBit;
        end

        // Selected reset input: three stages, filter, tick sample
        next_st.extSync = {st.extSync[1:0], extSel};
        extNew = filt(st.extSync, st.extLvl);
        next_st.extLvl = extNew;
        extRise = tick & extValid & st.extLvl & ~st.extCur;
        extFall = tick & extValid & ~st.extLvl & st.extCur;
        if (tick) begin
            next_st.extCur = st.extLvl;
        end
        next_st.extOut = st.extLvl;

        match = (st.count == st.periodBuf);

        // Counting
        if (!effOn) begin
            next_st.started = 1'b0;
        end else if (tick) begin
            case (mode)
                `TMH_MODE_MONO_RISE,
                `TMH_MODE_MONO_FALL,
                `TMH_MODE_MONO_BOTH: begin
                    if (!st.started) begin
                        if ((mode != `TMH_MODE_MONO_FALL && extRise) ||
                            (mode != `TMH_MODE_MONO_RISE && extFall)) begin
                            next_st.started = 1'b1;
                            next_st.periodBuf = st.period;
                        end
                    end else if (match) begin
                        next_st.count = `TMH_RST_BYTE;
                        next_st.started = 1'b0;
                        next_st.periodBuf = st.period;
                    end else begin
                        next_st.count = st.count + 8'h01;
                    end
                end
                `TMH_MODE_LVL_LOW,
                `TMH_MODE_LVL_HIGH: begin
                    if (extValid && (st.extLvl == mode[0])) begin
                        next_st.count = `TMH_RST_BYTE;
                        next_st.periodBuf = st.period;
                    end else if (match) begin
                        next_st.count = `TMH_RST_BYTE;
                        next_st.control[`TMH_ON_BIT] = 1'b0;
                        next_st.periodBuf = st.period;
                    end else begin
                        next_st.count = st.count + 8'h01;
                    end
                end
                default: begin
                    if (match) begin
                        next_st.count = `TMH_RST_BYTE;
                        next_st.periodBuf = st.period;
                    end else begin
                        next_st.count = st.count + 8'h01;
                    end
                end
            endcase
        end
        next_st.running = effOn;

        // APB slave: one wait state, answer registered
        next_st.rsp.pready = acc & ~st.rsp.pready;
        if (acc && !st.rsp.pready) begin
            next_st.rsp.prdata = apbReq.pwrite ? `TMH_RST_WORD : rdData;
            next_st.rsp.pslverr = unmapped;
        end
        if (wrEn) begin
            case (apbReq.paddr)
                `TMH_OFF_PERIOD: begin
                    next_st.period = apbReq.pwdata[7:0];
                end
                `TMH_OFF_COUNT: begin
                    next_st.count = apbReq.pwdata[7:0];
                    next_st.periodBuf = st.period;
                end
                `TMH_OFF_CONTROL: begin
                    next_st.control = apbReq.pwdata[7:0];
                    next_st.periodBuf = st.period;
                end
                `TMH_OFF_CLKSEL: begin
                    next_st.clkSel = apbReq.pwdata[3:0];
                end
                `TMH_OFF_RSTSEL: begin
                    next_st.rstSel = apbReq.pwdata[4:0];
                end
                `TMH_OFF_LIMIT: begin
                    next_st.limit = apbReq.pwdata[7:0];
                end
                default: begin
                    next_st.period = next_st.period;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign apbRsp = st.rsp;
    assign timerCount = st.count;
    assign periodBufOut = st.periodBuf;
    assign timerRunning = st.running;
    assign modeCode = st.limit[4:0];
    assign extResetLevel = st.extOut;
endmodule // tmh_timer

// >>> testbench/tmh_timer_chk.sv
`timescale 1ns/1ps
`include "tmh_params.svh"
module tmh_timer_chk
    import tmh_pkg::*;
#(
    parameter logic [4:0] SELF_SRC = 5'h01
) (
    input wire logic         clk,
    input wire logic         rst_n,
    input wire tmh_apb_req_s apbReq,
    input wire tmh_apb_rsp_s apbRsp,
    input wire logic         sleepMode,
    input wire logic [7:0]   timerCount,
    input wire logic [7:0]   periodBufOut,
    input wire logic         timerRunning,
    input wire logic [4:0]   modeCode,
    input wire logic         extResetLevel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       wrDone;
    logic       cw;
    logic       resv;
    logic [7:0] limReg;
    logic [4:0] rsel;
    logic [3:0] resCnt;
    logic [3:0] slpCnt;
    assign wrDone = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
    assign cw = wrDone && apbReq.paddr == `TMH_OFF_COUNT;
    assign resv = rsel > `TMH_SRC_LC_HI || rsel == SELF_SRC;
    // Shadow copies of the written selections
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            limReg <= 8'h00;
            rsel <= 5'h00;
        end else if (wrDone && apbReq.paddr == `TMH_OFF_LIMIT) begin
            limReg <= apbReq.pwdata[7:0];
        end else if (wrDone && apbReq.paddr == `TMH_OFF_RSTSEL) begin
            rsel <= apbReq.pwdata[4:0];
        end
    end
    always_ff @(posedge clk) begin
        resCnt <= (!rst_n || !resv) ? 4'h0 : resCnt + {3'h0, resCnt != 4'hF};
        slpCnt <= (!rst_n || !(sleepMode && limReg[7])) ? 4'h0 : slpCnt + {3'h0, slpCnt != 4'hF};
    end
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready high for more than one cycle");
    a_ready_after_access: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready
        |=> apbRsp.pready) else $error("pready late");
    a_mode_follows: assert property (wrDone && apbReq.paddr == `TMH_OFF_LIMIT
        |-> ##2 modeCode == limReg[4:0]) else $error("mode code not from limit control");
    a_rsel_read: assert property (apbRsp.pready && !apbReq.pwrite
        && apbReq.paddr == `TMH_OFF_RSTSEL |-> apbRsp.prdata == {27'h0, rsel})
        else $error("reset select read wrong");
    a_count_step: assert property (!cw ##1 $changed(timerCount)
        |-> timerCount == $past(timerCount) + 8'h01 || timerCount == 8'h00)
        else $error("count moved other than by one or to zero");
    a_wrap_zero: assert property (!cw && timerCount == periodBufOut
        ##1 $changed(timerCount) |-> timerCount == 8'h00) else $error("no clear after match");
    a_stop_keeps: assert property ((modeCode == 5'h00 && !timerRunning && !cw)[*4]
        |-> $stable(timerCount)) else $error("count moved while off");
    a_reserved_quiet: assert property (resCnt > 4'hA |-> !extResetLevel)
        else $error("reserved source gives active reset input");
    a_sleep_halt: assert property (slpCnt > 4'h7 && !cw |=> $stable(timerCount))
        else $error("count moved in sleep with prescaler sync");
endmodule // tmh_timer_chk

// >>> testbench/tmh_src_model.sv
`timescale 1ns/1ps
module tmh_src_model
    import tmh_pkg::*;
(
    input  wire logic [4:0] code,
    input  wire logic       level,
    output tmh_src_s        srcOut
);
    logic [17:0] v;
    // Unselected sources show the inverse level
    always_comb begin
        v = {18{~level}};
        if (code < 5'h12) begin
            v[code] = level;
        end
    end
    assign srcOut = '{inputPin: v[0], sibling: v[3:1], ccp: v[5:4], pwm: v[9:6],
                      cmp: v[13:10], zcd: v[14], lc: v[17:15]};
endmodule // tmh_src_model

// >>> testbench/timer_hw_limit_reset_select_tb_top.sv
`timescale 1ns/1ps
module timer_hw_limit_reset_select_tb_top
    import tmh_pkg::*;
;
    logic         clk;
    logic         rst_n;
    tmh_apb_req_s req;
    tmh_apb_rsp_s rsp;
    logic         tclk;
    logic         sleepMode;
    tmh_src_s     src;
    logic [7:0]   cnt;
    logic [4:0]   code;
    logic         level;
    logic         extLvl;
    logic [31:0]  rd;
    logic         er;
    logic [31:0]  seed;
    int           errCount;
    int           checksDone;
    int           cyc;
    logic [7:0]   mdl [6];
    logic [7:0]   msk [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F, 8'hFF};
    tmh_timer i_tmh_timer (.clk(clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
        .timerClkIn(tclk), .sleepMode(sleepMode), .srcIn(src), .timerCount(cnt),
        .periodBufOut(), .timerRunning(), .modeCode(), .extResetLevel(extLvl));
    tmh_src_model i_tmh_src_model (.code(code), .level(level), .srcOut(src));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, 8'(i * 4), d);
        mdl[i] = d[7:0] & msk[i];
    endtask
    task automatic rdc(input int i);
        apb(1'b0, 8'(i * 4), 32'h0000_0000);
        chk(rd, {24'h0, mdl[i]}, "register");
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            tclk <= ~tclk;
            repeat (4) @(posedge clk);
        end
        repeat (10) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 20000) begin
                errCount++;
                conclude();
            end
        end
    end
    initial begin
        rst_n = 1'b0; req = '0; tclk = 1'b0; sleepMode = 1'b0; code = 5'h00; level = 1'b0;
        seed = 32'hba0c_ff85;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000, "reset value");
            chk({31'h0, er}, 32'(i == 6), "slave error");
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr(i, (i == 2) ? seed & 32'hFFFF_FF7F : seed);
            rdc(i);
        end
        $display("end of register tests");
        wr(5, 32'h0000_0000);
        wr(0, 32'h0000_0005);
        wr(1, 32'h0000_0000);
        wr(2, 32'h0000_0080);
        edges(17);
        mdl[1] = 8'h03;
        rdc(1);
        wr(2, 32'h0000_0000);
        edges(6);
        rdc(1);
        wr(5, 32'h0000_0060);
        wr(1, 32'h0000_0000);
        wr(2, 32'h0000_0080);
        edges(7);
        mdl[1] = 8'h02;
        rdc(1);
        chk({24'h0, cnt}, 32'h0000_0002, "count port");
        wr(2, 32'h0000_0000);
        for (int p = 0; p < 2; p++) begin
            wr(5, p ? 32'h0000_0080 : 32'h0000_0000);
            wr(1, 32'h0000_0000);
            wr(2, 32'h0000_0080);
            sleepMode <= 1'b1;
            edges(8);
            sleepMode <= 1'b0;
            mdl[1] = p ? 8'h00 : 8'h04;
            rdc(1);
            wr(2, 32'h0000_0000);
        end
        $display("end of counting tests");
        for (int c = 0; c < 32; c++) begin
            wr(4, c);
            seed = xs(seed);
            level <= seed[0];
            code <= 5'(c);
            repeat (12) @(posedge clk);
            chk({31'h0, extLvl}, {31'h0, (c < 18 && c != 1) ? level : 1'b0}, "reset level");
        end
        wr(4, 32'h0000_0000);
        code <= 5'h00;
        level <= 1'b1;
        wr(0, 32'h0000_0003);
        wr(5, 32'h0000_0017);
        wr(1, 32'h0000_0002);
        wr(2, 32'h0000_0080);
        edges(4);
        mdl[1] = 8'h00;
        rdc(1);
        level <= 1'b0;
        repeat (8) @(posedge clk);
        edges(8);
        mdl[2] = 8'h00;
        rdc(1);
        rdc(2);
        wr(0, 32'h0000_0002);
        wr(5, 32'h0000_0011);
        wr(1, 32'h0000_0000);
        wr(2, 32'h0000_0080);
        edges(4);
        rdc(1);
        level <= 1'b1;
        repeat (8) @(posedge clk);
        edges(6);
        mdl[1] = 8'h02;
        rdc(1);
        edges(4);
        mdl[1] = 8'h00;
        rdc(1);
        $display("end of source and mode tests");
        conclude();
    end
endmodule // timer_hw_limit_reset_select_tb_top
bind tmh_timer tmh_timer_chk #(.SELF_SRC(SELF_SRC)) i_tmh_timer_chk (.clk(clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .sleepMode(sleepMode), .timerCount(timerCount),
    .periodBufOut(periodBufOut), .timerRunning(timerRunning), .modeCode(modeCode),
    .extResetLevel(extResetLevel));
